// File: tse_pkg.sv
// Package: register map, field positions and reset values of the status/event block
package tse_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] ADDR_EVENT_STATUS_ONE   = 8'h05;
    localparam logic [7:0] ADDR_OVERCAPTURE_STATUS = 8'h06;
    localparam logic [7:0] ADDR_EVENT_GENERATION   = 8'h07;

    ////////////////////////////////////////////////////////////////////////
    // Field positions, shared by status, generation and enable bytes
    localparam int BIT_BREAK   = 7;
    localparam int BIT_TRIGGER = 6;
    localparam int BIT_COMMUT  = 5;
    localparam int BIT_CH_LOW  = 1;
    localparam int BIT_UPDATE  = 0;
    localparam int NUM_CH      = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and masks
    localparam logic [7:0] STATUS_RESET     = 8'h00;
    localparam logic [7:0] GENERATION_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE        = 8'h00;
    localparam logic [1:0] DIR_OUTPUT       = 2'h0;
    localparam logic [1:0] ALIGN_EDGE_ONLY  = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic reg_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        reg_hit = (addr == target);
    endfunction : reg_hit

endpackage : tse_pkg

// File: tse_trigger_edge.sv
// Trigger edge detector: active rising edge, or both edges in gated mode
`timescale 1ns/1ns
`default_nettype none
module tse_trigger_edge (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic trigger_input,
    input  wire logic gated_trigger_mode,
    output logic      trigger_edge
);
    import tse_pkg::*;

    logic trigger_prev;

    always_ff @(posedge clk)
    begin
        if (reset)
            trigger_prev <= 1'b0;
        else
            trigger_prev <= trigger_input;
    end

    // Gated mode counts both edges as trigger events
    always_comb
    begin
        trigger_edge = (trigger_input & ~trigger_prev)
                     | (gated_trigger_mode & ~trigger_input & trigger_prev);
    end

endmodule : tse_trigger_edge
`default_nettype wire

// File: tse_channel_flags.sv
// One capture/compare channel: its compare/capture flag and overcapture flag
`timescale 1ns/1ns
`default_nettype none
module tse_channel_flags (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [1:0] direction,
    input  wire logic       compare_match,
    input  wire logic       beyond_reload_hit,
    input  wire logic       hw_capture,
    input  wire logic       sw_generate,
    input  wire logic       clear_capcomp,
    input  wire logic       clear_overcapture,
    input  wire logic       low_byte_read,
    output logic            capcomp_flag,
    output logic            overcapture_flag,
    output logic            sw_capture
);
    import tse_pkg::*;

    logic is_output;
    logic capture;
    logic set_capcomp;
    logic clr_capcomp;

    always_comb
    begin
        is_output   = (direction == DIR_OUTPUT);
        capture     = ~is_output & (hw_capture | sw_generate);
        set_capcomp = is_output
                    ? (compare_match | beyond_reload_hit | sw_generate)
                    : capture;
        clr_capcomp = clear_capcomp | (~is_output & low_byte_read);
    end

    // Set wins over any clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (reset)
            capcomp_flag <= 1'b0;
        else if (set_capcomp)
            capcomp_flag <= 1'b1;
        else if (clr_capcomp)
            capcomp_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            overcapture_flag <= 1'b0;
        else if (capture & capcomp_flag)
            overcapture_flag <= 1'b1;
        else if (clear_overcapture)
            overcapture_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            sw_capture <= 1'b0;
        else
            sw_capture <= sw_generate & ~is_output;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_overcapture;
        (capture && capcomp_flag) |=> overcapture_flag;
    endproperty
    a_overcapture: assert property (p_overcapture)
        else $error("overcapture flag missed");

    property p_low_read_clear;
        (!is_output && low_byte_read && !capture) |=> !capcomp_flag;
    endproperty
    a_low_read_clear: assert property (p_low_read_clear)
        else $error("low byte read did not clear flag");

endmodule : tse_channel_flags
`default_nettype wire

// File: tse_status_event.sv
// Timer status flags and software event generation, top level
//
// Contract
// - Break flag sets while break input active; clears only when input inactive.
// - Trigger flag sets on active trigger edge; both edges in gated mode.
// - Commutation flag sets when a commutation updates channel control bits.
// - Output channel flag sets when counter equals compare value.
// - Compare above reload sets flag on overflow, or underflow when down.
// - Input channel flag sets on capture; clears by write or low-byte read.
// - Update flag sets on overflow or underflow while update disable is 0.
// - Software or trigger reinit sets update flag if source and disable are 0.
// - Writing 0 clears a status flag, 1 leaves it; status resets to 0x00.
// - Overcapture flag sets on input capture while capture flag still set.
// - Reserved overcapture status bits read zero; software keeps them cleared.
// - Generation bits are write-only, self-clearing; writing 0 does nothing.
// - Break generation clears main output enable and sets break flag.
// - Trigger generation sets trigger flag and may raise an interrupt.
// - Commutation generation transfers preloaded control bits when preloaded.
// - Channel generation on output channel sets its flag.
// - Channel generation on input channel captures, sets flag, maybe overcapture.
// - Update generation reinits counter, makes update event, clears prescaler.
// - Update generation loads zero if centered or up, else reload value.
// - Interrupt request per flag only when its enable bit is 1.
// - Preloaded control bits apply on commutation, else immediately.
// - Direction value 00 selects output; other values select input.
`timescale 1ns/1ns
`default_nettype none
module tse_status_event (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] irq_enable,
    input  wire logic       break_input,
    input  wire logic       trigger_input,
    input  wire logic       gated_trigger_mode,
    input  wire logic       hw_commutation,
    input  wire logic       preloaded_control,
    input  wire logic       update_disable,
    input  wire logic       update_source_select,
    input  wire logic       count_down,
    input  wire logic [1:0] center_align_select,
    input  wire logic       counter_overflow,
    input  wire logic       counter_underflow,
    input  wire logic       trigger_reinit,
    input  wire logic [3:0] compare_match,
    input  wire logic [3:0] compare_beyond_reload,
    input  wire logic [3:0] capture_event,
    input  wire logic [7:0] ch_direction_select,
    input  wire logic [3:0] ch_capture_low_byte_read,
    output logic            main_output_enable_clear,
    output logic            control_transfer,
    output logic            update_event,
    output logic            counter_reinit,
    output logic            counter_load_reload,
    output logic            prescaler_clear,
    output logic      [3:0] sw_capture,
    output logic      [7:0] irq_request
);
    import tse_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic       wr_status_one;
    logic       wr_overcapture;
    logic       wr_generation;
    logic [7:0] event_generation;
    logic       break_flag;
    logic       trigger_flag;
    logic       commutation_flag;
    logic       update_flag;
    logic [3:0] channel_capcomp_flag;
    logic [3:0] overcapture_flag;
    logic [7:0] status_one;
    logic [7:0] status_two;
    logic       trigger_edge;
    logic       commutation_event;
    logic       update_hw_set;
    logic       centered;
    logic       beyond_tick;

    always_comb
    begin
        wr_status_one  = reg_write & reg_hit(reg_addr, ADDR_EVENT_STATUS_ONE);
        wr_overcapture = reg_write & reg_hit(reg_addr, ADDR_OVERCAPTURE_STATUS);
        wr_generation  = reg_write & reg_hit(reg_addr, ADDR_EVENT_GENERATION);
    end

    ////////////////////////////////////////////////////////////////////////
    // Event generation register

    // Holds a written 1 for one cycle, then drops it
    always_ff @(posedge clk)
    begin
        if (reset)
            event_generation <= GENERATION_RESET;
        else if (wr_generation)
            event_generation <= reg_wdata;
        else
            event_generation <= GENERATION_RESET;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event sources

    tse_trigger_edge u_trigger_edge (
        .clk                (clk),
        .reset              (reset),
        .trigger_input      (trigger_input),
        .gated_trigger_mode (gated_trigger_mode),
        .trigger_edge       (trigger_edge)
    );

    always_comb
    begin
        centered = (center_align_select != ALIGN_EDGE_ONLY);
        // Preload transfer from software or hardware commutation
        commutation_event = preloaded_control
                          & (event_generation[BIT_COMMUT] | hw_commutation);
        update_hw_set = ((counter_overflow | counter_underflow)
                         & ~update_disable)
                      | ((event_generation[BIT_UPDATE] | trigger_reinit)
                         & ~update_source_select & ~update_disable);
        // Overflow in up and up/down counting, underflow in down counting
        beyond_tick = (counter_overflow & (~count_down | centered))
                    | (counter_underflow & count_down & ~centered);
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags, set wins over clear

    always_ff @(posedge clk)
    begin
        if (reset)
            break_flag <= 1'b0;
        else if (break_input | event_generation[BIT_BREAK])
            break_flag <= 1'b1;
        else if (wr_status_one & ~reg_wdata[BIT_BREAK])
            break_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            trigger_flag <= 1'b0;
        else if (trigger_edge | event_generation[BIT_TRIGGER])
            trigger_flag <= 1'b1;
        else if (wr_status_one & ~reg_wdata[BIT_TRIGGER])
            trigger_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            commutation_flag <= 1'b0;
        else if (commutation_event)
            commutation_flag <= 1'b1;
        else if (wr_status_one & ~reg_wdata[BIT_COMMUT])
            commutation_flag <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            update_flag <= 1'b0;
        else if (update_hw_set)
            update_flag <= 1'b1;
        else if (wr_status_one & ~reg_wdata[BIT_UPDATE])
            update_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Capture/compare channels

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++)
        begin : g_ch
            tse_channel_flags u_ch (
                .clk               (clk),
                .reset             (reset),
                .direction         (ch_direction_select[2*ch +: 2]),
                .compare_match     (compare_match[ch]),
                .beyond_reload_hit (compare_beyond_reload[ch] & beyond_tick),
                .hw_capture        (capture_event[ch]),
                .sw_generate       (event_generation[BIT_CH_LOW + ch]),
                .clear_capcomp     (wr_status_one & ~reg_wdata[BIT_CH_LOW + ch]),
                .clear_overcapture (wr_overcapture & ~reg_wdata[BIT_CH_LOW + ch]),
                .low_byte_read     (ch_capture_low_byte_read[ch]),
                .capcomp_flag      (channel_capcomp_flag[ch]),
                .overcapture_flag  (overcapture_flag[ch]),
                .sw_capture        (sw_capture[ch])
            );
        end
    endgenerate

    always_comb
    begin
        status_one = {break_flag, trigger_flag, commutation_flag,
                      channel_capcomp_flag, update_flag};
        // Reserved bits always zero
        status_two = {3'h0, overcapture_flag, 1'b0};
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data in the cycle after the strobe only

    always_ff @(posedge clk)
    begin
        if (reset)
            reg_rdata <= READ_IDLE;
        else if (reg_read & reg_hit(reg_addr, ADDR_EVENT_STATUS_ONE))
            reg_rdata <= status_one;
        else if (reg_read & reg_hit(reg_addr, ADDR_OVERCAPTURE_STATUS))
            reg_rdata <= status_two;
        else
            reg_rdata <= READ_IDLE;
    end

    ////////////////////////////////////////////////////////////////////////
    // Event strobes to the rest of the timer

    always_ff @(posedge clk)
    begin
        if (reset)
            main_output_enable_clear <= 1'b0;
        else
            main_output_enable_clear <= event_generation[BIT_BREAK];
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            control_transfer <= 1'b0;
        else
            control_transfer <= commutation_event;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            update_event        <= 1'b0;
            counter_reinit      <= 1'b0;
            prescaler_clear     <= 1'b0;
            counter_load_reload <= 1'b0;
        end
        else
        begin
            update_event        <= event_generation[BIT_UPDATE]
                                 | ((counter_overflow | counter_underflow)
                                    & ~update_disable);
            counter_reinit      <= event_generation[BIT_UPDATE];
            prescaler_clear     <= event_generation[BIT_UPDATE];
            counter_load_reload <= event_generation[BIT_UPDATE]
                                 & count_down & ~centered;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            irq_request <= STATUS_RESET;
        else
            irq_request <= status_one & irq_enable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_gen_write(int b);
        wr_generation && reg_wdata[b];
    endsequence

    property p_break_hold;
        break_input |=> break_flag;
    endproperty
    a_break_hold: assert property (p_break_hold)
        else $error("break flag not held by active input");

    property p_trigger_set;
        trigger_edge |=> trigger_flag;
    endproperty
    a_trigger_set: assert property (p_trigger_set)
        else $error("trigger edge lost");

    property p_commutation_set;
        commutation_event |=> (commutation_flag && control_transfer);
    endproperty
    a_commutation_set: assert property (p_commutation_set)
        else $error("commutation flag or transfer missing");

    property p_update_overflow;
        (counter_overflow && !update_disable) |=> (update_flag && update_event);
    endproperty
    a_update_overflow: assert property (p_update_overflow)
        else $error("update on overflow missed");

    property p_update_sw;
        s_gen_write(BIT_UPDATE) ##1 (!update_source_select && !update_disable)
            |=> update_flag;
    endproperty
    a_update_sw: assert property (p_update_sw)
        else $error("update flag missed after update generation");

    property p_write_zero_clear;
        (wr_status_one && !reg_wdata[BIT_TRIGGER] && !trigger_edge
         && !event_generation[BIT_TRIGGER]) |=> !trigger_flag;
    endproperty
    a_write_zero_clear: assert property (p_write_zero_clear)
        else $error("write of zero did not clear flag");

    property p_reserved_zero;
        (reg_read && reg_addr == ADDR_OVERCAPTURE_STATUS)
            |=> (reg_rdata[7:5] == 3'h0 && !reg_rdata[0]);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bits not zero");

    property p_generation_self_clear;
        wr_generation ##1 !wr_generation |=> event_generation == GENERATION_RESET;
    endproperty
    a_generation_self_clear: assert property (p_generation_self_clear)
        else $error("generation bits did not self clear");

    property p_break_generate;
        s_gen_write(BIT_BREAK) |=> ##1 (main_output_enable_clear && break_flag);
    endproperty
    a_break_generate: assert property (p_break_generate)
        else $error("break generation incomplete");

    property p_load_select;
        s_gen_write(BIT_UPDATE) ##1 (count_down && !centered)
            |=> (counter_load_reload && counter_reinit && prescaler_clear);
    endproperty
    a_load_select: assert property (p_load_select)
        else $error("reload value not selected");

    property p_irq_gate;
        (update_flag && irq_enable[BIT_UPDATE]) |=> irq_request[BIT_UPDATE];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("enabled flag raised no request");

endmodule : tse_status_event
`default_nettype wire

// File: tb_tse_status_event.sv
// Self-checking bench for the timer status flags and event generation block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_tse_status_event;
    import tse_pkg::*;
    typedef struct packed
    {
        logic [7:0]  gen;
        logic [16:0] stim;
        logic [7:0]  exp1;
        logic [7:0]  exp2;
    } tse_row_t;
    logic       clk, reset, reg_write, reg_read, break_input, trigger_input;
    logic       gated_trigger_mode, hw_commutation, preloaded_control, update_disable;
    logic       update_source_select, count_down, counter_overflow, counter_underflow;
    logic       trigger_reinit, main_output_enable_clear, control_transfer, update_event;
    logic       counter_reinit, counter_load_reload, prescaler_clear;
    logic [1:0] center_align_select;
    logic [3:0] compare_match, compare_beyond_reload, capture_event;
    logic [3:0] ch_capture_low_byte_read, sw_capture;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_enable, ch_direction_select, irq_request;
    int         n_fail = 0, n_checks = 0, n_oe_clr = 0, n_xfer = 0, n_cap3 = 0, base;
    // Stim: ovf, udf, reinit, trigger, commutation, match[3:0], capture[3:0], low read[3:0]
    tse_row_t   rows [14] = '{
        '{8'h00, 17'h1_0000, 8'h05, 8'h00},
        '{8'h00, 17'h0_4000, 8'h01, 8'h00},
        '{8'h00, 17'h0_2000, 8'h40, 8'h00},
        '{8'h00, 17'h0_1000, 8'h20, 8'h00},
        '{8'h00, 17'h0_0100, 8'h02, 8'h00},
        '{8'h00, 17'h0_0800, 8'h00, 8'h00},
        '{8'h00, 17'h0_0040, 8'h08, 8'h00},
        '{8'h00, 17'h0_0010, 8'h00, 8'h00},
        '{8'h80, 17'h0_0000, 8'h80, 8'h00},
        '{8'h40, 17'h0_0000, 8'h40, 8'h00},
        '{8'h20, 17'h0_0000, 8'h20, 8'h00},
        '{8'h02, 17'h0_0000, 8'h02, 8'h00},
        '{8'h10, 17'h0_0000, 8'h10, 8'h00},
        '{8'h01, 17'h0_0000, 8'h01, 8'h00}};

    tse_status_event dut
    (
        .clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq_enable,
        .break_input, .trigger_input, .gated_trigger_mode, .hw_commutation, .preloaded_control,
        .update_disable, .update_source_select, .count_down, .center_align_select,
        .counter_overflow, .counter_underflow, .trigger_reinit, .compare_match,
        .compare_beyond_reload, .capture_event, .ch_direction_select, .ch_capture_low_byte_read,
        .main_output_enable_clear, .control_transfer, .update_event, .counter_reinit,
        .counter_load_reload, .prescaler_clear, .sw_capture, .irq_request
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pulse tallies, compared as differences
    always @(posedge clk)
    begin
        n_oe_clr <= n_oe_clr + int'(main_output_enable_clear === 1'b1);
        n_xfer <= n_xfer + int'(control_transfer === 1'b1);
        n_cap3 <= n_cap3 + int'(sw_capture[3] === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask : chk_rd

    task automatic pulse(input logic [16:0] s);
        @(posedge clk);
        {counter_overflow, counter_underflow, trigger_reinit, trigger_input, hw_commutation,
         compare_match, capture_event, ch_capture_low_byte_read} <= s;
        @(posedge clk);
        {counter_overflow, counter_underflow, trigger_reinit, trigger_input, hw_commutation,
         compare_match, capture_event, ch_capture_low_byte_read} <= '0;
    endtask : pulse

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {reg_write, reg_read, break_input, trigger_input, gated_trigger_mode} = '0;
        {hw_commutation, update_disable, update_source_select, count_down} = '0;
        {counter_overflow, counter_underflow, trigger_reinit, center_align_select} = '0;
        {compare_match, capture_event, ch_capture_low_byte_read} = '0;
        {reg_addr, reg_wdata, irq_enable} = '0;
        preloaded_control = 1'b1;
        compare_beyond_reload = 4'h2;
        ch_direction_select = 8'h50;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        `CHK(irq_request, 8'h00)
        chk_rd(ADDR_EVENT_STATUS_ONE, STATUS_RESET);
        chk_rd(ADDR_OVERCAPTURE_STATUS, STATUS_RESET);
        chk_rd(ADDR_EVENT_GENERATION, GENERATION_RESET);
        chk_rd(8'h08, READ_IDLE);
        wr(ADDR_EVENT_GENERATION, 8'h00);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        for (int i = 0; i < 14; i++)
        begin
            @(posedge clk);
            irq_enable <= i[0] ? 8'hFF : 8'h00;
            if (rows[i].gen !== 8'h00)
                wr(ADDR_EVENT_GENERATION, rows[i].gen);
            else
                pulse(rows[i].stim);
            repeat (2) @(posedge clk);
            chk_rd(ADDR_EVENT_STATUS_ONE, rows[i].exp1);
            chk_rd(ADDR_OVERCAPTURE_STATUS, rows[i].exp2);
            `CHK(irq_request, rows[i].exp1 & irq_enable)
            wr(ADDR_EVENT_STATUS_ONE, 8'h00);
            wr(ADDR_OVERCAPTURE_STATUS, 8'h00);
        end
        // Overcapture, reserved bits, low-byte clear
        pulse(17'h0_0040);
        pulse(17'h0_0040);
        base = n_cap3;
        wr(ADDR_EVENT_GENERATION, 8'h10);
        wr(ADDR_EVENT_GENERATION, 8'h10);
        repeat (2) @(posedge clk);
        #1;
        `CHK(n_cap3 - base, 2)
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h18);
        chk_rd(ADDR_OVERCAPTURE_STATUS, 8'h18);
        wr(ADDR_OVERCAPTURE_STATUS, 8'h1E);
        chk_rd(ADDR_OVERCAPTURE_STATUS, 8'h18);
        wr(ADDR_OVERCAPTURE_STATUS, 8'h16);
        chk_rd(ADDR_OVERCAPTURE_STATUS, 8'h10);
        pulse(17'h0_0004);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h10);
        pulse(17'h0_0008);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        wr(ADDR_OVERCAPTURE_STATUS, 8'h00);
        // Update disable, update source, reload direction
        @(posedge clk);
        update_disable <= 1'b1;
        pulse(17'h1_0000);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h04);
        wr(ADDR_EVENT_GENERATION, 8'h01);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h04);
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        update_disable <= 1'b0;
        update_source_select <= 1'b1;
        pulse(17'h0_4000);
        wr(ADDR_EVENT_GENERATION, 8'h01);
        @(posedge clk);
        #1;
        `CHK({update_event, counter_reinit, prescaler_clear, counter_load_reload}, 4'hE)
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        chk_rd(ADDR_EVENT_GENERATION, 8'h00);
        @(posedge clk);
        update_source_select <= 1'b0;
        count_down <= 1'b1;
        wr(ADDR_EVENT_GENERATION, 8'h01);
        @(posedge clk);
        #1;
        `CHK({update_event, counter_load_reload}, 2'h3)
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h01);
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        pulse(17'h0_8000);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h05);
        center_align_select <= 2'h1;
        wr(ADDR_EVENT_GENERATION, 8'h01);
        @(posedge clk);
        #1;
        `CHK(counter_load_reload, 1'b0)
        @(posedge clk);
        center_align_select <= 2'h0;
        count_down <= 1'b0;
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        // Break level holds the flag against clears
        break_input <= 1'b1;
        repeat (2) @(posedge clk);
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h80);
        break_input <= 1'b0;
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        base = n_oe_clr;
        wr(ADDR_EVENT_GENERATION, 8'h80);
        repeat (3) @(posedge clk);
        `CHK(n_oe_clr - base, 1)
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        // Clear and set in the same cycle
        @(posedge clk);
        {reg_write, reg_addr, reg_wdata, counter_overflow} <= {1'b1, 8'h05, 8'h00, 1'b1};
        @(posedge clk);
        {reg_write, counter_overflow} <= 2'b00;
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h05);
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        // Falling trigger edge counts only in gated mode
        trigger_input <= 1'b1;
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        trigger_input <= 1'b0;
        repeat (2) @(posedge clk);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        {gated_trigger_mode, trigger_input} <= 2'b11;
        repeat (2) @(posedge clk);
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        trigger_input <= 1'b0;
        repeat (2) @(posedge clk);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h40);
        // Commutation without and with preloaded control
        preloaded_control <= 1'b0;
        wr(ADDR_EVENT_STATUS_ONE, 8'h00);
        wr(ADDR_EVENT_GENERATION, 8'h20);
        chk_rd(ADDR_EVENT_STATUS_ONE, 8'h00);
        preloaded_control <= 1'b1;
        base = n_xfer;
        wr(ADDR_EVENT_GENERATION, 8'h20);
        repeat (3) @(posedge clk);
        `CHK(n_xfer - base, 1)
        // Reset in mid-run clears everything
        wr(ADDR_EVENT_GENERATION, 8'hC1);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chk_rd(ADDR_EVENT_STATUS_ONE, STATUS_RESET);
        close_out();
    end
endmodule : tb_tse_status_event
`default_nettype wire
